// ### smcg_pkg.sv
// Package of constants and types for the sleep mode clock gating controller.
package smcg_pkg;
    // ==========================================================
    // Sleep control register layout.
    localparam int SLEEP_EN_POS = 0;            // Sleep enable bit position.
    localparam int MODE_LSB = 1;                // Mode code low bit position.
    localparam int MODE_MSB = 3;                // Mode code high bit position.
    localparam logic [7:0] SLEEP_CTRL_RESET = 8'h00; // Sleep control reset value.
    localparam logic [7:0] SLEEP_CTRL_MASK = 8'h0F;  // Upper four bits read as zero.
    // ==========================================================
    // Clock gate register layout.
    localparam logic [7:0] CLK_GATE_RESET = 8'h00;   // Clock gate reset value.
    localparam logic [7:0] CLK_GATE_MASK = 8'hEF;    // Bit 4 is reserved and reads zero.
    localparam int GATE_CONV = 0;               // Converter gate bit.
    localparam int GATE_TIMER2 = 6;             // Asynchronous-capable timer gate bit.
    localparam int GATE_TWOWIRE = 7;            // Two-wire port gate bit.
    // ==========================================================
    // Mode codes.
    localparam logic [2:0] MODE_IDLE = 3'h0;    // Idle.
    localparam logic [2:0] MODE_NOISE = 3'h1;   // Converter noise reduction.
    localparam logic [2:0] MODE_PDOWN = 3'h2;   // Power-down.
    localparam logic [2:0] MODE_PSAVE = 3'h3;   // Power-save.
    localparam logic [2:0] MODE_STANDBY = 3'h6; // Standby.
    // ==========================================================
    // Timing counts.
    localparam int CLK_MHZ = 25;                // System clock rate.
    localparam int WAKE_STALL_CYCLES = 4;       // Extra stall after start-up.
    localparam int STANDBY_WAKE_CYCLES = 6;     // Standby wake time in cycles.
    localparam int STARTUP_DEFAULT = 16;        // Default fuse start-up count.
    localparam int CNT_W = 16;                  // Width of the wake counter.
    // Sequencer states, Gray coded along run, sleep, start-up, stall.
    typedef enum logic [1:0] {
        SMCG_RUN = 2'b00,
        SMCG_SLEEP = 2'b01,
        SMCG_START = 2'b11,
        SMCG_STALL = 2'b10
    } smcg_state_t;
endpackage

// ### smcg_clock_gate.sv
// Glitch-free clock gate cell built from a low-phase latch.
`timescale 1ns/100ps
module smcg_clock_gate (
    input wire logic clkIn,
    input wire logic gateOn,
    output logic clkOut
);
    // ==========================================================
    // Latch the enable while the clock is low so a change cannot clip a pulse.
    logic latchedOn; // Enable held through the high phase.
    always_latch begin
        if (!clkIn) begin
            latchedOn = gateOn;
        end
    end
    assign clkOut = clkIn & latchedOn;
endmodule

// ### smcg_sleep_ctrl.sv
// Sleep mode sequencer, wake qualification and clock gating top module.
`timescale 1ns/100ps
// Summary of operation
// - Sleep only on halt with enable set.
// - Interrupt wake stalls core four extra cycles.
// - Sleep never disturbs register file or memory.
// - Reset during sleep restarts at reset vector.
// - Idle stops only core and program clocks.
// - Idle or noise entry starts enabled conversion.
// - Noise mode also stops peripheral clock.
// - Noise mode wakes on its listed sources.
// - Power-down stops oscillator and generated clocks.
// - Power-down wakes on asynchronous sources only.
// - Deep modes wake on level external interrupts.
// - Power-down wake waits fuse start-up delay.
// - Power-save keeps enabled async timer waking.
// - Power-save stops unused timer clock sources.
// - Timer oscillator runs only in async mode.
// - Standby keeps oscillator, wakes in six cycles.
// - Gate bit stops and freezes peripheral clock.
// - Clearing gate bit resumes identical state.
// - Per-peripheral gating acts in active, idle.
// - Control register: mode bits 3..1, enable bit 0.
// - Mode codes 100, 101, 111 are reserved.
// - Gate register bit one stops module clock.
module smcg_sleep_ctrl (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clkEnable,
    input wire logic haltExec,
    input wire logic ctrlWrite,
    input wire logic [7:0] ctrlWriteData,
    output logic [7:0] sleepControlReg,
    input wire logic gateWrite,
    input wire logic [7:0] gateWriteData,
    output logic [7:0] clockGateReg,
    input wire logic crystalSelected,
    input wire logic [15:0] startupCycles,
    input wire logic timerAsync,
    input wire logic timerSync,
    input wire logic converterEnabled,
    input wire logic globalIrqEnable,
    input wire logic timer2IrqMaskHit,
    input wire logic anyIrqPending,
    input wire logic conversionDone,
    input wire logic watchdogEvent,
    input wire logic twoWireMatch,
    input wire logic memReadyIrq,
    input wire logic extIrqZero,
    input wire logic extIrqOne,
    input wire logic extIrqZeroLevel,
    input wire logic extIrqOneLevel,
    input wire logic pinChange,
    input wire logic resetSource,
    output logic coreStall,
    output logic restartFromVector,
    output logic conversionStart,
    output logic asleep,
    output logic [2:0] activeMode,
    output logic core_clock,
    output logic program_mem_clock,
    output logic peripheral_clock,
    output logic converter_clock,
    output logic async_timer_clock,
    output logic [7:0] periphClock,
    output logic mainOscEnable,
    output logic timerOscEnable,
    output logic periphAccessBlock
);
    // ==========================================================
    // Input synchronisers for asynchronous wake pins.
    logic [4:0] pinMeta;  // First stage, read only by second stage.
    logic [4:0] pinSync;  // Second stage, safe for logic.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pinMeta <= 5'h00;
            pinSync <= 5'h00;
        end else if (clkEnable) begin
            pinMeta <= {pinChange, extIrqOne, extIrqZero, twoWireMatch, resetSource};
            pinSync <= pinMeta;
        end
    end
    wire syncReset = pinSync[0];     // Reset source while asleep.
    wire syncTwoWire = pinSync[1];   // Two-wire address match.
    wire syncIrqZero = pinSync[2];   // External interrupt zero.
    wire syncIrqOne = pinSync[3];    // External interrupt one.
    wire syncPinChg = pinSync[4];    // Pin change.
    // ==========================================================
    // Register writes.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sleepControlReg <= smcg_pkg::SLEEP_CTRL_RESET;
            clockGateReg <= smcg_pkg::CLK_GATE_RESET;
        end else if (clkEnable) begin
            if (ctrlWrite) begin
                sleepControlReg <= ctrlWriteData & smcg_pkg::SLEEP_CTRL_MASK;
            end
            if (gateWrite) begin
                clockGateReg <= gateWriteData & smcg_pkg::CLK_GATE_MASK;
            end
        end
    end
    // ==========================================================
    // Mode decode.
    wire sleepEnable = sleepControlReg[smcg_pkg::SLEEP_EN_POS];
    wire [2:0] modeCode = sleepControlReg[smcg_pkg::MODE_MSB:smcg_pkg::MODE_LSB];
    wire modeIsStandby = (modeCode == smcg_pkg::MODE_STANDBY) && crystalSelected;
    // Reserved codes, and standby without a crystal, select nothing.
    wire modeDefined = (modeCode == smcg_pkg::MODE_IDLE) || (modeCode == smcg_pkg::MODE_NOISE) ||
                       (modeCode == smcg_pkg::MODE_PDOWN) || (modeCode == smcg_pkg::MODE_PSAVE) ||
                       modeIsStandby;
    wire sleepRequest = haltExec && sleepEnable && modeDefined;
    // ==========================================================
    // Wake qualification for the mode held while asleep.
    logic [2:0] heldMode; // Mode latched at sleep entry.
    wire inIdle = heldMode == smcg_pkg::MODE_IDLE;
    wire inNoise = heldMode == smcg_pkg::MODE_NOISE;
    wire inPsave = heldMode == smcg_pkg::MODE_PSAVE;
    // Outside idle, only level-sensed external interrupts wake.
    wire extWake = inIdle ? (syncIrqZero | syncIrqOne)
                          : ((syncIrqZero & extIrqZeroLevel) | (syncIrqOne & extIrqOneLevel));
    wire commonWake = extWake | syncPinChg | syncTwoWire | watchdogEvent;
    wire timerWake = timer2IrqMaskHit && globalIrqEnable && (inNoise ? timerAsync : 1'b1);
    wire irqWake = inIdle ? (anyIrqPending | commonWake) :
                   inNoise ? (commonWake | conversionDone | memReadyIrq | timerWake) :
                   inPsave ? (commonWake | timerWake) : commonWake;
    // ==========================================================
    // Sleep sequencer.
    smcg_pkg::smcg_state_t state;       // Current state.
    smcg_pkg::smcg_state_t next_state;  // Next state.
    logic [smcg_pkg::CNT_W-1:0] waitCount;      // Cycles left in start-up or stall.
    logic [smcg_pkg::CNT_W-1:0] next_waitCount; // Next wait count.
    wire [smcg_pkg::CNT_W-1:0] stallLoad = smcg_pkg::CNT_W'(smcg_pkg::WAKE_STALL_CYCLES - 1);
    wire [smcg_pkg::CNT_W-1:0] standbyLoad = smcg_pkg::CNT_W'(smcg_pkg::STANDBY_WAKE_CYCLES - 1);
    // Clock stopping modes wait the fuse start-up; standby its six cycles.
    wire oscStopped = !(inIdle || inNoise || heldMode == smcg_pkg::MODE_STANDBY);
    wire [smcg_pkg::CNT_W-1:0] startLoad = oscStopped
        ? ((startupCycles == 16'h0000) ? 16'h0000 : startupCycles - 16'h0001)
        : (heldMode == smcg_pkg::MODE_STANDBY ? standbyLoad : 16'h0000);
    always_comb begin
        next_state = state;
        next_waitCount = waitCount;
        case (state)
            smcg_pkg::SMCG_RUN: begin
                if (sleepRequest) begin
                    next_state = smcg_pkg::SMCG_SLEEP;
                end
            end
            smcg_pkg::SMCG_SLEEP: begin
                if (irqWake) begin
                    next_state = smcg_pkg::SMCG_START;
                    next_waitCount = startLoad;
                end
            end
            smcg_pkg::SMCG_START: begin
                if (waitCount == 16'h0000) begin
                    next_state = smcg_pkg::SMCG_STALL;
                    next_waitCount = stallLoad;
                end else begin
                    next_waitCount = waitCount - 16'h0001;
                end
            end
            default: begin
                if (waitCount == 16'h0000) begin
                    next_state = smcg_pkg::SMCG_RUN;
                end else begin
                    next_waitCount = waitCount - 16'h0001;
                end
            end
        endcase
    end
    // State, held mode and reset restart flag.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= smcg_pkg::SMCG_RUN;
            waitCount <= 16'h0000;
            heldMode <= smcg_pkg::MODE_IDLE;
            restartFromVector <= 1'b0;
        end else if (clkEnable) begin
            if (state != smcg_pkg::SMCG_RUN && syncReset) begin
                state <= smcg_pkg::SMCG_RUN;
                waitCount <= 16'h0000;
                restartFromVector <= 1'b1;
            end else begin
                state <= next_state;
                waitCount <= next_waitCount;
                restartFromVector <= 1'b0;
            end
            if (state == smcg_pkg::SMCG_RUN && sleepRequest) begin
                heldMode <= modeCode;
            end
        end
    end
    // Start an enabled conversion on entry to idle or noise reduction.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            conversionStart <= 1'b0;
        end else if (clkEnable) begin
            conversionStart <= sleepRequest && (state == smcg_pkg::SMCG_RUN) && converterEnabled &&
                               (modeCode == smcg_pkg::MODE_IDLE || modeCode == smcg_pkg::MODE_NOISE);
        end
    end
    // ==========================================================
    // Clock domain enables; only clocks are stopped, no storage is cleared.
    wire sleeping = state == smcg_pkg::SMCG_SLEEP;
    assign asleep = sleeping;
    assign activeMode = sleeping ? heldMode : 3'h0;
    assign coreStall = state != smcg_pkg::SMCG_RUN;
    wire coreOn = state == smcg_pkg::SMCG_RUN;
    wire periphOn = !sleeping || inIdle;
    wire convOn = !sleeping || inIdle || inNoise;
    wire timerOscOn = timerAsync && (!sleeping || inIdle || inNoise || inPsave);
    wire asyncOn = timerOscOn;
    wire mainOscOn = !sleeping || inIdle || inNoise ||
                     heldMode == smcg_pkg::MODE_STANDBY || (inPsave && timerSync);
    assign mainOscEnable = mainOscOn;
    assign timerOscEnable = timerOscOn;
    assign periphAccessBlock = |clockGateReg;
    // ==========================================================
    // Gate cells for the domain clocks.
    smcg_clock_gate coreGate (.clkIn(sys_clk), .gateOn(coreOn), .clkOut(core_clock));
    smcg_clock_gate memGate (.clkIn(sys_clk), .gateOn(coreOn), .clkOut(program_mem_clock));
    smcg_clock_gate ioGate (.clkIn(sys_clk), .gateOn(periphOn), .clkOut(peripheral_clock));
    smcg_clock_gate convGate (.clkIn(sys_clk), .gateOn(convOn), .clkOut(converter_clock));
    smcg_clock_gate asyGate (.clkIn(sys_clk), .gateOn(asyncOn), .clkOut(async_timer_clock));
    // Per-peripheral gates; the sync timer clock also runs in power-save.
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : gPeriph
            wire timerKeep = (g == smcg_pkg::GATE_TIMER2) && sleeping && inPsave && timerSync;
            wire convKeep = (g == smcg_pkg::GATE_CONV) && sleeping && inNoise;
            wire on = !clockGateReg[g] && (periphOn || timerKeep || convKeep);
            smcg_clock_gate pGate (.clkIn(sys_clk), .gateOn(on), .clkOut(periphClock[g]));
        end
    endgenerate
endmodule

// ### smcg_sleep_ctrl_sva.sv
// Checker of sleep entry, wake timing and clock gating.
`timescale 1ns/100ps
module smcg_sleep_ctrl_chk (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clkEnable,
    input wire logic haltExec,
    input wire logic [7:0] sleepControlReg,
    input wire logic [7:0] clockGateReg,
    input wire logic crystalSelected,
    input wire logic resetSource,
    input wire logic coreStall,
    input wire logic restartFromVector,
    input wire logic asleep,
    input wire logic [2:0] activeMode,
    input wire logic core_clock,
    input wire logic peripheral_clock,
    input wire logic converter_clock,
    input wire logic mainOscEnable,
    input wire logic periphAccessBlock
);
    // ==========================================================
    // Register, entry and clock checks, all in the system domain.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    AST_CTRL_UPPER: assert property (sleepControlReg[7:4] == 4'h0)
        else $error("Sleep control upper bits not zero.");
    AST_GATE_BIT4: assert property (clockGateReg[4] == 1'b0)
        else $error("Gate register bit 4 not zero.");
    AST_HALT_NO_EN: assert property (haltExec && !sleepControlReg[0] && !coreStall |=> !asleep && !coreStall)
        else $error("Halt without enable slept.");
    AST_HALT_ENTER: assert property (haltExec && clkEnable && sleepControlReg[0] && !coreStall
        && (!sleepControlReg[3] || (sleepControlReg[3:1] == 3'h6 && crystalSelected))
        |=> asleep && activeMode == $past(sleepControlReg[3:1]))
        else $error("Halt did not enter the chosen mode.");
    AST_RESERVED: assert property (haltExec && !coreStall && sleepControlReg[3]
        && sleepControlReg[2:1] != 2'b10 |=> !asleep && !coreStall)
        else $error("Reserved mode code slept.");
    AST_IDLE_CLK: assert property (@(negedge sys_clk) asleep && $past(asleep) && activeMode == 3'h0
        |-> !core_clock && peripheral_clock && converter_clock)
        else $error("Idle clock set wrong.");
    AST_NOISE_CLK: assert property (@(negedge sys_clk) asleep && $past(asleep) && activeMode == 3'h1
        |-> !core_clock && !peripheral_clock && converter_clock)
        else $error("Noise mode clock set wrong.");
    AST_DEEP_CLK: assert property (@(negedge sys_clk) asleep && $past(asleep)
        && activeMode inside {3'h2, 3'h3, 3'h6}
        |-> !core_clock && !peripheral_clock && !converter_clock)
        else $error("Deep mode clock still running.");
    AST_PDOWN_OSC: assert property (asleep && activeMode == 3'h2 |-> !mainOscEnable)
        else $error("Oscillator runs in power-down.");
    AST_STBY_OSC: assert property (asleep && activeMode == 3'h6 |-> mainOscEnable)
        else $error("Oscillator stopped in standby.");
    AST_WAKE_STALL: assert property ($fell(asleep) && !resetSource |-> coreStall [*5])
        else $error("Core released too early after wake.");
    AST_GATE_BLOCK: assert property (periphAccessBlock == (clockGateReg != 8'h00))
        else $error("Access block does not follow gate bits.");
    // Main scenarios reached.
    COV_SLEEP: cover property ($rose(asleep));
    COV_RESUME: cover property ($fell(coreStall));
    COV_VECTOR: cover property (restartFromVector);
endmodule
bind smcg_sleep_ctrl smcg_sleep_ctrl_chk chk (.sys_clk, .reset_n, .clkEnable, .haltExec, .sleepControlReg,
    .clockGateReg, .crystalSelected, .resetSource, .coreStall, .restartFromVector, .asleep, .activeMode,
    .core_clock, .peripheral_clock, .converter_clock, .mainOscEnable, .periphAccessBlock);

// ### smcg_wake_model.sv
// Model of the interrupt sources that wake the controller.
`timescale 1ns/100ps
module smcg_wake_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic coreStall,
    input wire logic [8:0] wakeReq,
    output logic [8:0] wakeLine
);
    // ==========================================================
    // A raised source holds its level until the core runs again.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wakeLine <= 9'h000;
        end else begin
            wakeLine <= (wakeLine & {9{coreStall}}) | wakeReq;
        end
    end
endmodule

// ### tb_top.sv
// Self-checking testbench of the sleep controller.
`timescale 1ns/100ps
module tb_top;
    // ==========================================================
    // Stimulus and observed signals.
    logic sys_clk = 1'b0, reset_n = 1'b0, haltExec = 1'b0, ctrlWrite = 1'b0, gateWrite = 1'b0;
    logic crystalSelected = 1'b1, timerAsync = 1'b1, timerSync = 1'b0, converterEnabled = 1'b1;
    logic globalIrqEnable = 1'b1, extIrqZeroLevel = 1'b1, extIrqOneLevel = 1'b1, resetSource = 1'b0;
    logic [7:0] ctrlWriteData = 8'h00, gateWriteData = 8'h00, sleepControlReg, clockGateReg, periphClock;
    logic [15:0] startupCycles = 16'h0004;
    logic [8:0] wakeReq = 9'h000, wakeLine;
    logic coreStall, restartFromVector, conversionStart, asleep, core_clock, program_mem_clock;
    logic peripheral_clock, converter_clock, async_timer_clock, mainOscEnable, timerOscEnable;
    logic periphAccessBlock, convSeen, vecSeen;
    logic [2:0] activeMode;
    logic [2:0] rsv [4] = '{3'h4, 3'h5, 3'h7, 3'h6};
    int nMismatch = 0, checks = 0, n;
    always #20 sys_clk = ~sys_clk;
    smcg_wake_model wake (.sys_clk, .reset_n, .coreStall, .wakeReq, .wakeLine);
    smcg_sleep_ctrl dut (.sys_clk, .reset_n, .clkEnable(1'b1), .haltExec, .ctrlWrite, .ctrlWriteData,
        .sleepControlReg, .gateWrite, .gateWriteData, .clockGateReg, .crystalSelected, .startupCycles,
        .timerAsync, .timerSync, .converterEnabled, .globalIrqEnable, .timer2IrqMaskHit(wakeLine[2]),
        .anyIrqPending(wakeLine[0]), .conversionDone(wakeLine[1]), .watchdogEvent(wakeLine[7]),
        .twoWireMatch(wakeLine[6]), .memReadyIrq(wakeLine[8]), .extIrqZero(wakeLine[3]),
        .extIrqOne(wakeLine[4]), .extIrqZeroLevel, .extIrqOneLevel, .pinChange(wakeLine[5]),
        .resetSource, .coreStall, .restartFromVector, .conversionStart, .asleep, .activeMode, .core_clock,
        .program_mem_clock, .peripheral_clock, .converter_clock, .async_timer_clock, .periphClock,
        .mainOscEnable, .timerOscEnable, .periphAccessBlock);
    // Pulse outputs are latched so that short events are not missed.
    always @(posedge sys_clk) begin
        if (conversionStart === 1'b1) convSeen = 1'b1;
        if (restartFromVector === 1'b1) vecSeen = 1'b1;
    end
    // ==========================================================
    // Shared tasks.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            nMismatch++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("TB: checks %0d mismatches %0d", checks, nMismatch);
        if (nMismatch == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic sel, input logic [7:0] d);
        @(posedge sys_clk);
        ctrlWrite <= !sel;
        gateWrite <= sel;
        ctrlWriteData <= d;
        gateWriteData <= d;
        @(posedge sys_clk);
        ctrlWrite <= 1'b0;
        gateWrite <= 1'b0;
    endtask
    task automatic halt;
        @(posedge sys_clk);
        haltExec <= 1'b1;
        @(posedge sys_clk);
        haltExec <= 1'b0;
        convSeen = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic pulse(input logic [8:0] v);
        @(posedge sys_clk);
        wakeReq <= v;
        @(posedge sys_clk);
        wakeReq <= 9'h000;
    endtask
    // Sleeps in mode m, tries a source that must not wake, then counts stall cycles after the wake.
    task automatic run_mode(input logic [2:0] m, input logic [15:0] su, input int good, input int bad,
        input logic lvl, input logic [15:0] exp);
        logic [15:0] len;
        logic [6:0] clkExp;
        @(posedge sys_clk);
        startupCycles <= su;
        extIrqZeroLevel <= lvl;
        extIrqOneLevel <= lvl;
        wr(1'b0, {4'h0, m, 1'b1});
        halt;
        check(16'(asleep), 16'h1);
        check(16'(activeMode), 16'(m));
        check(16'(convSeen), 16'(m < 3'h2));
        // Expected domain clocks and oscillators while asleep, sampled in the high phase of the clock.
        case (m)
            3'h0: clkExp = 7'h1F;
            3'h1: clkExp = 7'h0F;
            3'h3: clkExp = {4'h0, timerAsync, timerSync, timerAsync};
            3'h6: clkExp = 7'h02;
            default: clkExp = 7'h00;
        endcase
        check(16'({core_clock, program_mem_clock, peripheral_clock, converter_clock, async_timer_clock,
            mainOscEnable, timerOscEnable}), 16'(clkExp));
        pulse(9'h001 << bad);
        repeat (8) @(posedge sys_clk);
        #1 check(16'(asleep), 16'h1);
        pulse(9'h001 << good);
        n = 0;
        while (asleep === 1'b1 && n < 400) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (n == 400) begin
            nMismatch++;
            final_report;
        end
        len = 16'h0000;
        while (coreStall === 1'b1 && len < 16'h0190) begin
            @(posedge sys_clk);
            #1 len++;
        end
        check(len, exp);
        $display("TB: mode %h done", m);
    endtask
    // ==========================================================
    // Main sequence.
    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        #1 check(16'(sleepControlReg), 16'h0000);
        check(16'(clockGateReg), 16'h0000);
        wr(1'b0, 8'hFF);
        #1 check(16'(sleepControlReg), 16'h000F);
        wr(1'b0, 8'h04);
        halt;
        check(16'(asleep), 16'h0);
        crystalSelected <= 1'b0;
        foreach (rsv[i]) begin
            wr(1'b0, {4'h0, rsv[i], 1'b1});
            halt;
            check(16'({asleep, coreStall}), 16'h0);
        end
        crystalSelected <= 1'b1;
        converterEnabled <= 1'b0;
        wr(1'b1, 8'hFF);
        @(posedge sys_clk);
        #5 check(16'({clockGateReg, periphClock & 8'hEF}), 16'hEF00);
        check(16'(periphAccessBlock), 16'h1);
        wr(1'b1, 8'h00);
        @(posedge sys_clk);
        #5 check(16'(periphClock & 8'hEF), 16'h00EF);
        converterEnabled <= 1'b1;
        $display("TB: registers and refusals done");
        run_mode(3'h0, 16'h4, 0, 9, 1'b1, 16'h0005);
        run_mode(3'h1, 16'h4, 8, 3, 1'b0, 16'h0005);
        run_mode(3'h1, 16'h4, 4, 9, 1'b1, 16'h0005);
        run_mode(3'h2, 16'h4, 3, 1, 1'b1, 16'h0008);
        run_mode(3'h2, 16'h7, 6, 0, 1'b1, 16'h000B);
        run_mode(3'h3, 16'h4, 2, 8, 1'b1, 16'h0008);
        run_mode(3'h3, 16'h4, 7, 9, 1'b1, 16'h0008);
        run_mode(3'h6, 16'h4, 5, 0, 1'b1, 16'h000A);
        // Power-save with the timer on the synchronous clock keeps the main source and drops the timer oscillator.
        timerAsync <= 1'b0;
        timerSync <= 1'b1;
        run_mode(3'h3, 16'h4, 7, 9, 1'b1, 16'h0008);
        timerAsync <= 1'b1;
        timerSync <= 1'b0;
        wr(1'b0, 8'h05);
        halt;
        vecSeen = 1'b0;
        @(posedge sys_clk);
        resetSource <= 1'b1;
        repeat (8) @(posedge sys_clk);
        resetSource <= 1'b0;
        #1 check(16'({vecSeen, asleep, coreStall}), 16'h0004);
        $display("TB: reset in sleep done");
        final_report;
    end
endmodule
